// *** src/gtp_defs.svh ***
`ifndef GTP_DEFS_SVH
`define GTP_DEFS_SVH
// Summary of operation
// [R1] Every register is one 32-bit word on the register port.
// [R2] Reserved bits read as zero and the host writes them as zero.
// [R3] Register offsets are decoded relative to the register space base.
// [R4] The queried tag register at 0x7C is an 8-bit read-only tag, reset zero, from the query point.
// [R5] The queried tag is kept apart from the live touch tag, which follows the touch point.
// [R6] The Y query register at 0x78 holds an 11-bit coordinate, reset zero, written by the host.
// [R7] The X query register at 0x74 holds an 11-bit coordinate, reset zero, written by the host.
// [R8] The divisor in bits 7..0 at 0x70 divides the main clock to make the pixel clock.
// [R9] A divisor of zero stops the pixel clock output entirely.
// [R10] Bit 0 at 0x6C picks the active pixel clock edge, zero rising and one falling.
// [R11] Bit 0 at 0x68 staggers the colour line transitions when set, else all switch together.
// [R12] Bits 3..0 at 0x64 select the colour line ordering for the panel; bits above are reserved.
`define GTP_OFS_LINE_ORDER 8'h64
`define GTP_OFS_SPREAD 8'h68
`define GTP_OFS_EDGE 8'h6C
`define GTP_OFS_DIVISOR 8'h70
`define GTP_OFS_TAG_X 8'h74
`define GTP_OFS_TAG_Y 8'h78
`define GTP_OFS_TAG 8'h7C
`define GTP_RST_LINE_ORDER 4'h0
`define GTP_RST_SPREAD 1'h0
`define GTP_RST_EDGE 1'h0
`define GTP_RST_DIVISOR 8'h00
`define GTP_RST_COORD 11'h000
`define GTP_RST_TAG 8'h00
`define GTP_SPREAD_STEP 2'h1
`endif

// *** src/gtp_pkg.sv ***
package gtp_pkg;
	typedef logic [7:0] gtp_tag_t;
	typedef logic [10:0] gtp_coord_t;
	typedef logic [7:0] gtp_color_t;
	typedef enum logic [1:0] {
		GTP_Q_IDLE,
		GTP_Q_ASK,
		GTP_Q_WAIT
	} gtp_qstate_t;
endpackage

// *** src/gtp_pclk_if.sv ***
`timescale 1ns/1ps
interface gtp_pclk_if;
	logic [7:0] divisor;
	logic edge_falling;
	logic pclk;
	logic launch;
	modport gen (input divisor, input edge_falling, output pclk, output launch);
	modport use_side (output divisor, output edge_falling, input pclk, input launch);
endinterface

// *** src/gtp_pclk_gen.sv ***
`timescale 1ns/1ps
`include "gtp_defs.svh"
module gtp_pclk_gen (
	input wire logic clk_sys,
	input wire logic nrst,
	gtp_pclk_if.gen pif
);
	import gtp_pkg::*;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic ph_reg;
	logic ph_next;
	logic launch_reg;
	wire run = pif.divisor != `GTP_RST_DIVISOR;
	wire wrap = cnt_reg + 8'h01 >= pif.divisor;
	wire half = (cnt_reg + 8'h01) == (pif.divisor >> 1);
	// Output period is divisor main clock cycles: high for divisor/2, low for the rest. [R8]
	assign cnt_next = (!run || wrap) ? 8'h00 : cnt_reg + 8'h01;
	assign ph_next = !run ? 1'b0 : (wrap ? 1'b1 : (half ? 1'b0 : ph_reg));
	// A divisor of one cannot toggle at the main rate, so it holds high as a constant level.
	assign pif.pclk = run && (pif.divisor == 8'h01 ? 1'b1 : ph_reg); // [R9]
	// The launch point sits half a period before the panel samples on the chosen edge.
	wire rise_now = run && wrap;
	wire fall_now = run && half;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= `GTP_RST_DIVISOR;
			ph_reg <= 1'b0;
			launch_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			ph_reg <= ph_next;
			launch_reg <= pif.edge_falling ? rise_now : fall_now; // [R10]
		end
	end
	assign pif.launch = launch_reg;
endmodule

// *** src/gtp_regs.sv ***
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "gtp_defs.svh"
module gtp_regs #(
	parameter logic [31:0] REG_BASE = 32'h0000_0000
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output gtp_pkg::gtp_coord_t query_x,
	output gtp_pkg::gtp_coord_t query_y,
	output logic query_req,
	input wire logic query_ack,
	input wire gtp_pkg::gtp_tag_t query_tag,
	input wire gtp_pkg::gtp_tag_t touch_tag_live,
	input wire gtp_pkg::gtp_color_t pix_red,
	input wire gtp_pkg::gtp_color_t pix_green,
	input wire gtp_pkg::gtp_color_t pix_blue,
	output logic pclk_out,
	output logic [23:0] rgb_out,
	output logic [3:0] rgb_pin_order
);
	import gtp_pkg::*;
	gtp_pclk_if pif ();
	// Decode is relative to the register space base; only the low byte selects the word. [R3]
	wire [31:0] rel = reg_addr - REG_BASE;
	wire in_space = rel[31:8] == 24'h000000 && rel[1:0] == 2'h0;
	wire [7:0] ofs = rel[7:0];
	wire sel_order = in_space && ofs == `GTP_OFS_LINE_ORDER;
	wire sel_spread = in_space && ofs == `GTP_OFS_SPREAD;
	wire sel_edge = in_space && ofs == `GTP_OFS_EDGE;
	wire sel_div = in_space && ofs == `GTP_OFS_DIVISOR;
	wire sel_x = in_space && ofs == `GTP_OFS_TAG_X;
	wire sel_y = in_space && ofs == `GTP_OFS_TAG_Y;
	wire sel_tag = in_space && ofs == `GTP_OFS_TAG;

	logic [3:0] order_reg;
	logic spread_reg;
	logic edge_reg;
	logic [7:0] div_reg;
	gtp_coord_t x_reg;
	gtp_coord_t y_reg;
	gtp_tag_t tag_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	gtp_qstate_t qs_reg;
	gtp_qstate_t qs_next;
	logic pend_reg;

	// Only the documented field widths are stored; reserved write bits are dropped. [R2]
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			order_reg <= `GTP_RST_LINE_ORDER;
			spread_reg <= `GTP_RST_SPREAD;
			edge_reg <= `GTP_RST_EDGE;
			div_reg <= `GTP_RST_DIVISOR;
		end else begin
			if (reg_wr && sel_order) order_reg <= reg_wdata[3:0]; // [R12]
			if (reg_wr && sel_spread) spread_reg <= reg_wdata[0]; // [R11]
			if (reg_wr && sel_edge) edge_reg <= reg_wdata[0]; // [R10]
			if (reg_wr && sel_div) div_reg <= reg_wdata[7:0]; // [R8]
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			x_reg <= `GTP_RST_COORD;
			y_reg <= `GTP_RST_COORD;
		end else begin
			if (reg_wr && sel_x) x_reg <= reg_wdata[10:0]; // [R7]
			if (reg_wr && sel_y) y_reg <= reg_wdata[10:0]; // [R6]
		end
	end

	// A coordinate write during a lookup marks a fresh lookup so the newest point wins.
	wire coord_wr = reg_wr && (sel_x || sel_y);
	always_comb begin
		qs_next = qs_reg;
		case (qs_reg)
			GTP_Q_IDLE: begin
				if (coord_wr || pend_reg) qs_next = GTP_Q_ASK;
			end
			GTP_Q_ASK: begin
				qs_next = GTP_Q_WAIT;
			end
			GTP_Q_WAIT: begin
				if (query_ack) qs_next = GTP_Q_IDLE;
			end
			default: begin
				qs_next = GTP_Q_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			qs_reg <= GTP_Q_IDLE;
			pend_reg <= 1'b0;
			tag_reg <= `GTP_RST_TAG;
		end else begin
			qs_reg <= qs_next;
			pend_reg <= (qs_reg != GTP_Q_IDLE && coord_wr) || (pend_reg && qs_reg != GTP_Q_IDLE);
			// Only the lookup answer loads this tag, never the live touch tag. [R4] [R5]
			if (qs_reg == GTP_Q_WAIT && query_ack) tag_reg <= query_tag;
		end
	end

	assign query_req = qs_reg == GTP_Q_ASK;
	assign query_x = x_reg;
	assign query_y = y_reg;

	// Read data is zero-extended to the word; unmapped offsets read zero. [R1] [R2]
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (sel_order) rdata_next = {28'h0000000, order_reg};
		if (sel_spread) rdata_next = {31'h00000000, spread_reg};
		if (sel_edge) rdata_next = {31'h00000000, edge_reg};
		if (sel_div) rdata_next = {24'h000000, div_reg};
		if (sel_x) rdata_next = {21'h000000, x_reg};
		if (sel_y) rdata_next = {21'h000000, y_reg};
		if (sel_tag) rdata_next = {24'h000000, tag_reg}; // [R4]
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			rdata_reg <= reg_rd ? rdata_next : 32'h0000_0000;
		end
	end
	assign reg_rdata = rdata_reg;

	assign pif.divisor = div_reg;
	assign pif.edge_falling = edge_reg;
	gtp_pclk_gen u_pclk (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pif(pif)
	);

	// Colour lines are launched on the pixel clock's launch point. With spreading on,
	// the middle and low bytes (green and blue in order 0) follow one and two main clocks later, trading skew for less noise.
	logic [23:0] stage_reg;
	logic [1:0] lag_reg;
	logic [23:0] ordered;
	always_comb begin
		case (order_reg)
			4'h1: ordered = {pix_blue, pix_green, pix_red};
			4'h2: ordered = {pix_green, pix_red, pix_blue};
			4'h3: ordered = {pix_red, pix_blue, pix_green};
			default: ordered = {pix_red, pix_green, pix_blue};
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stage_reg <= 24'h000000;
			rgb_out <= 24'h000000;
			lag_reg <= 2'h0;
			pclk_out <= 1'b0;
		end else begin
			pclk_out <= pif.pclk;
			if (pif.launch) begin
				stage_reg <= ordered;
				lag_reg <= spread_reg ? `GTP_SPREAD_STEP : 2'h0;
				if (spread_reg) rgb_out[23:16] <= ordered[23:16]; // [R11]
				else rgb_out <= ordered;
			end else if (lag_reg == `GTP_SPREAD_STEP) begin
				rgb_out[15:8] <= stage_reg[15:8];
				lag_reg <= 2'h2;
			end else if (lag_reg == 2'h2) begin
				rgb_out[7:0] <= stage_reg[7:0];
				lag_reg <= 2'h0;
			end
		end
	end
	assign rgb_pin_order = order_reg; // [R12]
endmodule

// *** sim/gtp_regs_asserts.sv ***
`timescale 1ns/1ps
module gtp_regs_asserts #(
	parameter logic [31:0] REG_BASE = 32'h0000_0000
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire gtp_pkg::gtp_coord_t query_x,
	input wire gtp_pkg::gtp_coord_t query_y,
	input wire logic query_req,
	input wire logic pclk_out,
	input wire logic [3:0] rgb_pin_order
);
	import gtp_pkg::*;
	logic [7:0] div_reg;
	wire wr_x = reg_wr && reg_addr == REG_BASE + 32'h74;
	wire wr_y = reg_wr && reg_addr == REG_BASE + 32'h78;
	wire wr_ord = reg_wr && reg_addr == REG_BASE + 32'h64;
	wire wr_div = reg_wr && reg_addr == REG_BASE + 32'h70;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Shadow of the divisor, so a stopped clock can be judged from the ports alone.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			div_reg <= 8'h00;
		end else if (wr_div) begin
			div_reg <= reg_wdata[7:0];
		end
	end
	sequence s_div_off;
		div_reg == 8'h00 [*4];
	endsequence
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside the read cycle");
	a_resv_zero: assert property (reg_rdata[31:11] == 21'h0)
		else $error("reserved read bits not zero");
	a_x_write: assert property (wr_x |=> query_x == $past(reg_wdata[10:0]))
		else $error("x coordinate not taken");
	a_y_write: assert property (wr_y |=> query_y == $past(reg_wdata[10:0]))
		else $error("y coordinate not taken");
	a_x_hold: assert property (!wr_x |=> $stable(query_x))
		else $error("x coordinate changed without a write");
	a_order_write: assert property (wr_ord |=> rgb_pin_order == $past(reg_wdata[3:0]))
		else $error("line order not taken");
	a_unmapped_read: assert property (reg_rd && reg_addr == REG_BASE + 32'h80 |=> reg_rdata == 0)
		else $error("unmapped read not zero");
	a_req_pulse: assert property (query_req |=> !query_req)
		else $error("lookup request longer than one cycle");
	a_pclk_stop: assert property (s_div_off |-> !pclk_out)
		else $error("pixel clock runs with zero divisor");
endmodule
bind gtp_regs gtp_regs_asserts #(.REG_BASE(REG_BASE)) chk (.clk_sys(clk_sys), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .query_x(query_x), .query_y(query_y), .query_req(query_req),
	.pclk_out(pclk_out), .rgb_pin_order(rgb_pin_order));

// *** sim/gtp_tag_model.sv ***
`timescale 1ns/1ps
module gtp_tag_model #(
	parameter int DELAY = 3
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic query_req,
	input wire gtp_pkg::gtp_coord_t query_x,
	input wire gtp_pkg::gtp_coord_t query_y,
	output logic query_ack,
	output gtp_pkg::gtp_tag_t query_tag
);
	import gtp_pkg::*;
	int cnt;
	// Outside the answer cycle the tag flips each cycle, so a stale sample cannot pass.
	always_ff @(posedge clk_sys) begin
		cnt <= !nrst ? 0 : query_req ? DELAY : cnt > 0 ? cnt - 1 : 0;
		query_ack <= nrst && cnt == 1;
		if (!nrst) query_tag <= 8'h5A;
		else query_tag <= cnt == 1 ? query_x[7:0] + query_y[7:0] : ~query_tag;
	end
endmodule

// *** sim/graphics_tag_and_pixel_clock_regs_bench.sv ***
`timescale 1ns/1ps
module graphics_tag_and_pixel_clock_regs_bench;
	import gtp_pkg::*;
	localparam logic [31:0] BASE = 32'h0000_1000;
	logic clk_sys, nrst, reg_wr, reg_rd, query_req, query_ack, pclk_out;
	logic [31:0] reg_addr, reg_wdata, reg_rdata;
	logic [23:0] rgb_out;
	logic [3:0] rgb_pin_order;
	logic [7:0] pr, pg, pb;
	gtp_coord_t query_x, query_y;
	gtp_tag_t query_tag;
	int fail_count = 0;
	int compares = 0;
	gtp_regs #(.REG_BASE(BASE)) uut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.query_x(query_x), .query_y(query_y), .query_req(query_req), .query_ack(query_ack),
		.query_tag(query_tag), .touch_tag_live(8'hA5), .pix_red(pr), .pix_green(pg),
		.pix_blue(pb), .pclk_out(pclk_out), .rgb_out(rgb_out), .rgb_pin_order(rgb_pin_order));
	gtp_tag_model peer (.clk_sys(clk_sys), .nrst(nrst), .query_req(query_req), .query_x(query_x),
		.query_y(query_y), .query_ack(query_ack), .query_tag(query_tag));
	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(logic [31:0] ofs, logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= BASE + ofs;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [31:0] ofs, logic [31:0] exp, string name);
		@(posedge clk_sys);
		reg_addr <= BASE + ofs;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		check(name, exp, reg_rdata);
	endtask
	task automatic t_reset;
		for (int a = 'h64; a <= 'h7C; a += 4) begin
			rd(32'(a), 32'h0, "reset value");
		end
		$display("test reset done");
	endtask
	task automatic t_fields;
		logic [31:0] mask [6] = '{32'hF, 32'h1, 32'h1, 32'hFF, 32'h7FF, 32'h7FF};
		for (int i = 0; i < 6; i++) begin
			wr(32'h64 + 32'(4 * i), 32'hFFFF_FFFF);
			rd(32'h64 + 32'(4 * i), mask[i], "field width");
		end
		check("line order port", 32'hF, 32'(rgb_pin_order));
		rd(32'h80, 32'h0, "unmapped");
		rd(32'h74 - BASE, 32'h0, "outside space");
		$display("test fields done");
	endtask
	task automatic t_tag;
		wr(32'h74, 32'h123);
		wr(32'h78, 32'h245);
		for (int i = 0; i < 50 && !(query_ack === 1'b1 && query_tag === 8'h68); i++) begin
			@(posedge clk_sys);
		end
		rd(32'h7C, 32'h68, "queried tag");
		wr(32'h7C, 32'hFF);
		rd(32'h7C, 32'h68, "read-only tag");
		$display("test tag done");
	endtask
	// The red lines move on the launch point; blue trails by two clocks when spreading is on.
	task automatic t_rgb(logic edge_sel, logic spread);
		int t_red = -1;
		int t_blue = -1;
		wr(32'h70, 32'h4);
		wr(32'h6C, 32'(edge_sel));
		wr(32'h68, 32'(spread));
		wr(32'h64, 32'h0);
		pr <= 8'h11;
		pg <= 8'h22;
		pb <= 8'h33;
		repeat (12) @(posedge clk_sys);
		pr <= 8'h44;
		pg <= 8'h55;
		pb <= 8'h66;
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_sys);
			#1;
			if (t_red < 0 && rgb_out[23:16] == 8'h44) begin
				t_red = i;
				check("pclk at launch", 32'(edge_sel), 32'(pclk_out));
			end
			if (t_blue < 0 && rgb_out[7:0] == 8'h66) t_blue = i;
		end
		check("colour skew", spread ? 32'h2 : 32'h0, 32'(t_blue - t_red));
		check("colour lines", 32'h445566, 32'(rgb_out));
		$display("test rgb edge %0d spread %0d done", edge_sel, spread);
	endtask
	task automatic t_pclk(logic [7:0] d, int exp);
		int n = 0;
		logic prev;
		wr(32'h70, 32'(d));
		repeat (8) @(posedge clk_sys);
		prev = pclk_out;
		repeat (40) begin
			@(posedge clk_sys);
			n += int'(pclk_out && !prev);
			prev = pclk_out;
		end
		check("pixel clock rises", 32'(exp), 32'(n));
		$display("test pclk divisor %0d done", d);
	endtask
	task give_verdict;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 32'h0;
		reg_wdata = 32'h0;
		pr = 8'h00;
		pg = 8'h00;
		pb = 8'h00;
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset;
		t_fields;
		t_tag;
		t_rgb(1'b0, 1'b0);
		t_rgb(1'b1, 1'b1);
		t_pclk(8'h05, 8);
		t_pclk(8'h00, 0);
		give_verdict;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		give_verdict;
	end
endmodule
